// ---- pwrsc_pkg.sv ----
// Purpose: shared constants and types of the power-state and reset controller
// Assumes: 100 MHz system clock
// Notes:   timing counts derived from times in their own units
package pwrsc_pkg;

	localparam int unsigned PWRSC_CLK_MHZ      = 100;
	localparam int unsigned PWRSC_FILT_CYCLES  = 3;
	localparam int unsigned PWRSC_WAKE_US      = 100;
	localparam int unsigned PWRSC_WAKE_CYCLES  = PWRSC_WAKE_US * PWRSC_CLK_MHZ;
	localparam int unsigned PWRSC_NUM_IN       = 7;

	// bit positions of the filtered power-state inputs
	localparam int unsigned PWRSC_B_MAIN  = 0;
	localparam int unsigned PWRSC_B_EN    = 1;
	localparam int unsigned PWRSC_B_IGS   = 2;
	localparam int unsigned PWRSC_B_EGS   = 3;
	localparam int unsigned PWRSC_B_LOGIC = 4;
	localparam int unsigned PWRSC_B_BKUP  = 5;
	localparam int unsigned PWRSC_B_IDLE  = 6;

	localparam logic [6:0] PWRSC_IN_RESET = 7'h00;

	typedef enum logic [2:0]
	{
		PWRSC_OFF,
		PWRSC_SLEEP,
		PWRSC_WAKE,
		PWRSC_IDLE,
		PWRSC_LIMP,
		PWRSC_ACTIVE
	} pwrsc_state_e;

endpackage

// ---- pwrsc_filter.sv ----
// Purpose: per-bit input filter for the power-state inputs
// Assumes: asynchronous inputs, one clock domain
// Notes:   three flops plus an output flop, change accepted when stages two and three agree
`timescale 1ns/1ps
module pwrsc_filter
	import pwrsc_pkg::*;
#(
	parameter int unsigned WIDTH = PWRSC_NUM_IN
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] filt
);

	initial
	begin
		if (WIDTH < 1)
			$error("pwrsc_filter: WIDTH must be at least one");
	end

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] filt_q;
	wire  [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
	wire  [WIDTH-1:0] filt_d = (agree & s3_q) | (~agree & filt_q);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			filt_q <= '0;
		end
		else
		begin
			s1_q   <= raw;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d;
		end
	end

	assign filt = filt_q;

endmodule // pwrsc_filter

// ---- pwrsc_ctrl.sv ----
// Purpose: power-state selection and register reset control of an LED driver
// Assumes: supply levels arrive as digital comparator indications
// Notes:   SPI engine and register file sit outside; this block gates them
//
// Summary of operation
// - a power-state input change counts only after four cycles of filtering
// - state derives from five inputs: main and logic supplies, enable pin, backup input, idle bit
// - power-up starts once the main supply indication is above start-up threshold
// - sleep holds gate regulator, switching, drivers and SPI off and the registers in reset
// - sleep to active takes a wake-up interval; host waits for it
// - idle performs no switching; regulators stay enabled
// - idle with logic supply keeps registers working and accepts SPI
// - entering limp home returns every register to default
// - limp home serves reads and ignores every register write
// - limp home regulates only with main and external gate supply good
// - active switches only while the dimming input is high
// - each high-side driver is enabled only with its bootstrap supply good
// - any reset event sets the transmission error flag
// - enable-pin undervoltage disables SPI, resets registers and enters sleep
// - enable-pin undervoltage turns off gate regulator, switching and communication
// - logic undervoltage blocks drivers, refuses SPI and holds registers at default
// - gate supply undervoltage stops drivers and switching, registers kept
// - soft reset restores writable registers except the output mux register
// - calibration result survives soft reset; readable only with readout enable
`timescale 1ns/1ps
module pwrsc_ctrl
	import pwrsc_pkg::*;
#(
	parameter int unsigned WAKE_CYCLES = PWRSC_WAKE_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       main_supply_ok,
	input  wire logic       enable_undervoltage_pin,
	input  wire logic       internal_gate_supply_ok,
	input  wire logic       external_gate_supply_ok,
	input  wire logic       logic_supply_ok,
	input  wire logic       backup_mode_input,
	input  wire logic       idle_request_bit,
	input  wire logic       pwm_dim_input,
	input  wire logic [1:0] bootstrap_ok,
	input  wire logic       soft_reset_cmd,
	input  wire logic       calib_readout_enable,
	input  wire logic       spi_write_req,
	input  wire logic       spi_read_req,
	input  wire logic       ter_clear,
	output logic            soft_reset_bit,
	output logic            reg_reset,
	output logic            soft_reset_pulse,
	output logic            mux_reg_reset,
	output logic            spi_enable,
	output logic            spi_write_allow,
	output logic            spi_read_allow,
	output logic            calib_read_allow,
	output logic            gate_regulator_en,
	output logic            switching_en,
	output logic [1:0]      high_side_drivers,
	output logic            low_side_driver_en,
	output logic            transmission_error_flag,
	output logic            active_ready,
	output pwrsc_state_e    power_state
);

	initial
	begin
		if (WAKE_CYCLES < 1)
			$error("pwrsc_ctrl: WAKE_CYCLES must be at least one");
		if (PWRSC_B_IDLE >= PWRSC_NUM_IN)
			$error("pwrsc_ctrl: input bit map exceeds the filter width");
	end

	localparam int unsigned WCW = $clog2(WAKE_CYCLES + 1);
	localparam logic [WCW-1:0] WAKE_LAST = WCW'(WAKE_CYCLES - 1);

	// ------------------------------------------------------------------
	// input filtering
	// ------------------------------------------------------------------
	wire  [PWRSC_NUM_IN-1:0] raw_in;
	logic [PWRSC_NUM_IN-1:0] f_in;

	assign raw_in[PWRSC_B_MAIN]  = main_supply_ok;
	assign raw_in[PWRSC_B_EN]    = enable_undervoltage_pin;
	assign raw_in[PWRSC_B_IGS]   = internal_gate_supply_ok;
	assign raw_in[PWRSC_B_EGS]   = external_gate_supply_ok;
	assign raw_in[PWRSC_B_LOGIC] = logic_supply_ok;
	assign raw_in[PWRSC_B_BKUP]  = backup_mode_input;
	assign raw_in[PWRSC_B_IDLE]  = idle_request_bit;

	pwrsc_filter #(
		.WIDTH (PWRSC_NUM_IN)
	) u_filter (
		.clk  (clk),
		.rst  (rst),
		.raw  (raw_in),
		.filt (f_in)
	);

	wire main_ok  = f_in[PWRSC_B_MAIN];
	wire en_ok    = f_in[PWRSC_B_EN];
	wire igs_ok   = f_in[PWRSC_B_IGS];
	wire egs_ok   = f_in[PWRSC_B_EGS];
	wire logic_ok = f_in[PWRSC_B_LOGIC];
	wire bkup     = f_in[PWRSC_B_BKUP];
	wire idle_req = f_in[PWRSC_B_IDLE];

	// pwm and bootstrap are fast analog-side levels; same three-flop agree filter plus output flop
	logic [2:0] pwm_s1_q;
	logic [2:0] pwm_s2_q;
	logic [2:0] pwm_s3_q;
	wire  [2:0] fast_raw = {bootstrap_ok, pwm_dim_input};
	wire  [2:0] fast_agree = ~(pwm_s2_q ^ pwm_s3_q);
	logic [2:0] fast_q;
	wire  [2:0] fast_d = (fast_agree & pwm_s3_q) | (~fast_agree & fast_q);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pwm_s1_q <= 3'h0;
			pwm_s2_q <= 3'h0;
			pwm_s3_q <= 3'h0;
			fast_q   <= 3'h0;
		end
		else
		begin
			pwm_s1_q <= fast_raw;
			pwm_s2_q <= pwm_s1_q;
			pwm_s3_q <= pwm_s2_q;
			fast_q   <= fast_d;
		end
	end

	wire       pwm_hi = fast_q[0];
	wire [1:0] bst_ok = fast_q[2:1];

	// ------------------------------------------------------------------
	// state class decoding
	// ------------------------------------------------------------------
	// states in which the register file is held at defaults
	function automatic logic is_rest_state(input pwrsc_state_e s);
		is_rest_state = (s == PWRSC_OFF) || (s == PWRSC_SLEEP);
	endfunction

	// states reached only once the wake interval has run out
	function automatic logic is_awake_state(input pwrsc_state_e s);
		is_awake_state = (s == PWRSC_IDLE) || (s == PWRSC_LIMP) || (s == PWRSC_ACTIVE);
	endfunction

	// target among the awake states; backup mode wins over the idle request
	function automatic pwrsc_state_e awake_target(input logic bk, input logic idl);
		if (bk)
			awake_target = PWRSC_LIMP;
		else if (idl)
			awake_target = PWRSC_IDLE;
		else
			awake_target = PWRSC_ACTIVE;
	endfunction

	// ------------------------------------------------------------------
	// state selection
	// ------------------------------------------------------------------
	pwrsc_state_e state_q;
	pwrsc_state_e state_d;
	logic [WCW-1:0] wake_cnt_q;
	logic [WCW-1:0] wake_cnt_d;

	wire powered = main_ok;
	wire wake_done = (wake_cnt_q == WAKE_LAST);

	always_comb
	begin
		state_d    = state_q;
		wake_cnt_d = wake_cnt_q;
		case (state_q)
			PWRSC_OFF:
			begin
				if (powered)
					state_d = PWRSC_SLEEP;
			end
			PWRSC_SLEEP:
			begin
				wake_cnt_d = '0;
				if (en_ok && logic_ok)
					state_d = PWRSC_WAKE;
			end
			PWRSC_WAKE:
			begin
				if (!en_ok || !logic_ok)
					state_d = PWRSC_SLEEP;
				else if (wake_done)
					state_d = awake_target(bkup, idle_req);
				else
					wake_cnt_d = wake_cnt_q + WCW'(1);
			end
			PWRSC_IDLE,
			PWRSC_LIMP,
			PWRSC_ACTIVE:
			begin
				if (!en_ok)
					state_d = PWRSC_SLEEP;
				else if (!logic_ok)
					state_d = PWRSC_SLEEP;
				else
					state_d = awake_target(bkup, idle_req);
			end
			default:
			begin
				state_d = PWRSC_OFF;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q    <= PWRSC_OFF;
			wake_cnt_q <= '0;
		end
		else
		begin
			state_q    <= state_d;
			wake_cnt_q <= wake_cnt_d;
		end
	end

	// ------------------------------------------------------------------
	// register reset control
	// ------------------------------------------------------------------
	wire in_sleep  = is_rest_state(state_q);
	wire in_idle   = (state_q == PWRSC_IDLE);
	wire in_limp   = (state_q == PWRSC_LIMP);
	wire in_active = (state_q == PWRSC_ACTIVE);
	// next state is used so the register reset lands with the move itself
	wire limp_entry = (state_d == PWRSC_LIMP) && !in_limp;

	logic swrst_q;
	logic ter_q;
	logic uv_reset_q;

	wire swrst_apply = swrst_q && !in_sleep && logic_ok;
	wire uv_reset = !en_ok || !logic_ok || in_sleep;
	// a held undervoltage counts as one reset event, on its leading edge
	wire any_reset = (uv_reset && !uv_reset_q) || limp_entry || swrst_apply;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			swrst_q    <= 1'b0;
			ter_q      <= 1'b1;
			uv_reset_q <= 1'b1;
		end
		else
		begin
			uv_reset_q <= uv_reset;
			// soft reset command latches; clears once applied
			if (swrst_apply || uv_reset)
				swrst_q <= 1'b0;
			else if (soft_reset_cmd && spi_write_allow)
				swrst_q <= 1'b1;
			// set wins over clear
			if (any_reset)
				ter_q <= 1'b1;
			else if (ter_clear)
				ter_q <= 1'b0;
		end
	end

	assign soft_reset_bit          = swrst_q;
	assign reg_reset               = uv_reset || limp_entry;
	assign soft_reset_pulse        = swrst_apply;
	assign mux_reg_reset           = uv_reset || limp_entry;
	assign transmission_error_flag = ter_q;

	// ------------------------------------------------------------------
	// SPI gating
	// ------------------------------------------------------------------
	wire spi_ok = !in_sleep && en_ok && logic_ok;

	assign spi_enable       = spi_ok;
	assign spi_read_allow   = spi_ok && spi_read_req;
	assign spi_write_allow  = spi_ok && spi_write_req && !in_limp;
	assign calib_read_allow = spi_read_allow && calib_readout_enable;

	// ------------------------------------------------------------------
	// regulator and driver gating
	// ------------------------------------------------------------------
	wire gate_sup_ok = igs_ok && egs_ok;
	wire run_active  = in_active && pwm_hi;
	wire run_limp    = in_limp && main_ok && egs_ok;
	wire sw_ok = (run_active || run_limp) && gate_sup_ok && logic_ok && !in_idle;

	assign gate_regulator_en  = !in_sleep && en_ok;
	assign switching_en       = sw_ok;
	assign low_side_driver_en = sw_ok;
	assign high_side_drivers  = {2{sw_ok}} & bst_ok;
	assign active_ready       = is_awake_state(state_q);
	assign power_state        = state_q;

endmodule // pwrsc_ctrl

// ---- pwrsc_ctrl_assertions.sv ----
// Purpose: port checks of the power-state and reset controller
// Assumes: bound to pwrsc_ctrl, one clock domain
// Notes:   filtered inputs settle within six cycles
`timescale 1ns/1ps
module pwrsc_ctrl_assertions
	import pwrsc_pkg::*;
#(
	parameter int unsigned WAKE_CYCLES = PWRSC_WAKE_CYCLES
)
(
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         enable_undervoltage_pin,
	input wire logic         logic_supply_ok,
	input wire logic         pwm_dim_input,
	input wire logic [1:0]   bootstrap_ok,
	input wire logic         soft_reset_cmd,
	input wire logic         calib_readout_enable,
	input wire logic         soft_reset_bit,
	input wire logic         reg_reset,
	input wire logic         soft_reset_pulse,
	input wire logic         mux_reg_reset,
	input wire logic         spi_enable,
	input wire logic         spi_write_allow,
	input wire logic         calib_read_allow,
	input wire logic         gate_regulator_en,
	input wire logic         switching_en,
	input wire logic [1:0]   high_side_drivers,
	input wire logic         transmission_error_flag,
	input wire logic         active_ready,
	input wire pwrsc_state_e power_state
);
	// ----------------
	// checks
	// ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_swrst;
		soft_reset_bit && soft_reset_pulse ##1 !soft_reset_bit;
	endsequence
	AST_SLEEP_OFF: assert property (power_state == PWRSC_SLEEP |->
		!switching_en && !spi_enable && !gate_regulator_en && reg_reset) else $error("sleep output");
	AST_EN_LOW: assert property ((!enable_undervoltage_pin [*8]) |->
		power_state inside {PWRSC_OFF, PWRSC_SLEEP}) else $error("enable low not sleep");
	AST_LOGIC_UV: assert property ((!logic_supply_ok [*6]) |->
		reg_reset && !spi_enable && high_side_drivers == 2'h0) else $error("logic uv");
	AST_IDLE_NOSW: assert property (power_state == PWRSC_IDLE |-> !switching_en)
		else $error("switching in idle");
	AST_LIMP_NOWR: assert property (power_state == PWRSC_LIMP |-> !spi_write_allow)
		else $error("write in limp");
	AST_PWM_LOW: assert property ((!pwm_dim_input [*6]) ##0 power_state == PWRSC_ACTIVE
		|-> !switching_en) else $error("switching with dim low");
	AST_BOOT_LOW: assert property ((!bootstrap_ok[0] [*6]) |-> !high_side_drivers[0])
		else $error("driver on without bootstrap");
	AST_SWRST: assert property (soft_reset_cmd && spi_write_allow |=> s_swrst)
		else $error("soft reset sequence");
	AST_TER_SET: assert property (soft_reset_pulse |-> !mux_reg_reset
		##[0:1] transmission_error_flag) else $error("soft reset flag or mux");
	AST_CAL: assert property (calib_read_allow |->
		calib_readout_enable) else $error("calib read");
	AST_WAKE: assert property (power_state == PWRSC_WAKE |-> !active_ready)
		else $error("ready during wake");
endmodule // pwrsc_ctrl_assertions

bind pwrsc_ctrl pwrsc_ctrl_assertions #(.WAKE_CYCLES(WAKE_CYCLES)) i_pwrsc_ctrl_assertions (.*);

// ---- pwrsc_host_model.sv ----
// Purpose: host controller model driving the control bits
// Assumes: bits change at the falling edge
// Notes:   soft reset write lasts one cycle
`timescale 1ns/1ps
module pwrsc_host_model
(
	input  wire logic clk,
	output logic      idle_request_bit,
	output logic      soft_reset_cmd,
	output logic      calib_readout_enable,
	output logic      spi_write_req,
	output logic      spi_read_req,
	output logic      ter_clear
);
	// ----------------
	// host accesses
	// ----------------
	initial
	begin
		{idle_request_bit, soft_reset_cmd, calib_readout_enable} = 3'h0;
		{spi_write_req, spi_read_req, ter_clear} = 3'h0;
	end
	task automatic wr(input logic idle, input logic swrst, input logic cal);
		@(negedge clk);
		{spi_write_req, soft_reset_cmd} = {1'b1, swrst};
		{idle_request_bit, calib_readout_enable} = {idle, cal};
		@(negedge clk);
		{spi_write_req, soft_reset_cmd} = 2'h0;
	endtask
	task automatic req_hold(input logic wr_on, input logic rd_on);
		@(negedge clk);
		{spi_write_req, spi_read_req} = {wr_on, rd_on};
	endtask
	task automatic rd_clear();
		@(negedge clk);
		{spi_read_req, ter_clear} = 2'h3;
		@(negedge clk);
		{spi_read_req, ter_clear} = 2'h0;
	endtask
endmodule // pwrsc_host_model

// ---- tb_pwrsc_ctrl.sv ----
// Purpose: self-checking bench of the power-state controller
// Assumes: inputs change at the falling edge
// Notes:   wake interval shortened to 20 cycles
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
	$display("wrong value at %0t: got %h, expected %h", $time, a, e); end end
module tb_pwrsc_ctrl;
	import pwrsc_pkg::*;
	// ----------------
	// bench
	// ----------------
	localparam int unsigned WAKE = 20;
	int           err_count = 0;
	int           comparisons = 0;
	int           n;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         main_supply_ok, enable_undervoltage_pin, internal_gate_supply_ok;
	logic         external_gate_supply_ok, logic_supply_ok, backup_mode_input, pwm_dim_input;
	logic [1:0]   bootstrap_ok, high_side_drivers;
	logic         idle_request_bit, soft_reset_cmd, calib_readout_enable;
	logic         spi_write_req, spi_read_req, ter_clear, soft_reset_bit, reg_reset;
	logic         soft_reset_pulse, mux_reg_reset, spi_enable, spi_write_allow, spi_read_allow;
	logic         calib_read_allow, gate_regulator_en, switching_en, low_side_driver_en;
	logic         transmission_error_flag, active_ready;
	pwrsc_state_e power_state;
	always #5 clk = ~clk;
	pwrsc_ctrl #(.WAKE_CYCLES(WAKE)) i_pwrsc_ctrl (.*);
	pwrsc_host_model i_pwrsc_host_model (.*);
	task automatic report_and_stop();
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// order: main, enable, internal gate, external gate, logic, backup, dim, bootstrap
	task automatic sup(input logic [8:0] v, input int w);
		@(negedge clk);
		{main_supply_ok, enable_undervoltage_pin, internal_gate_supply_ok,
			external_gate_supply_ok, logic_supply_ok, backup_mode_input,
			pwm_dim_input, bootstrap_ok} = v;
		repeat (w) @(negedge clk);
	endtask
	task automatic wait_ready();
		n = 0;
		while (active_ready !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		if (active_ready !== 1'b1)
		begin
			err_count++;
			report_and_stop();
		end
	endtask
	initial
	begin
		{main_supply_ok, enable_undervoltage_pin, internal_gate_supply_ok} = 3'h0;
		{external_gate_supply_ok, logic_supply_ok, backup_mode_input} = 3'h0;
		{pwm_dim_input, bootstrap_ok} = 3'h0;
		repeat (2) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		`CHK(power_state, PWRSC_OFF)
		`CHK(transmission_error_flag, 1'b1)
		sup(9'h100, 8);
		`CHK(power_state, PWRSC_SLEEP)
		`CHK(spi_enable, 1'b0)
		`CHK(active_ready, 1'b0)
		sup(9'h1F5, 0);
		wait_ready();
		`CHK(n > WAKE, 1'b1)
		`CHK(power_state, PWRSC_ACTIVE)
		`CHK(switching_en, 1'b1)
		`CHK(low_side_driver_en, 1'b1)
		`CHK(high_side_drivers, 2'h1)
		sup(9'h1F1, 8);
		`CHK(switching_en, 1'b0)
		sup(9'h1F6, 8);
		`CHK(high_side_drivers, 2'h2)
		i_pwrsc_host_model.rd_clear();
		`CHK(transmission_error_flag, 1'b0)
		i_pwrsc_host_model.wr(1'b0, 1'b1, 1'b0);
		`CHK(soft_reset_pulse, 1'b1)
		`CHK(mux_reg_reset, 1'b0)
		`CHK(soft_reset_bit, 1'b1)
		@(negedge clk);
		`CHK(soft_reset_bit, 1'b0)
		`CHK(transmission_error_flag, 1'b1)
		i_pwrsc_host_model.wr(1'b0, 1'b0, 1'b1);
		i_pwrsc_host_model.req_hold(1'b0, 1'b1);
		#1 `CHK(calib_read_allow, 1'b1)
		i_pwrsc_host_model.req_hold(1'b0, 1'b0);
		i_pwrsc_host_model.wr(1'b1, 1'b0, 1'b0);
		repeat (8) @(negedge clk);
		i_pwrsc_host_model.req_hold(1'b1, 1'b1);
		#1 `CHK(calib_read_allow, 1'b0)
		`CHK(power_state, PWRSC_IDLE)
		`CHK(switching_en, 1'b0)
		`CHK(gate_regulator_en, 1'b1)
		`CHK(spi_write_allow, 1'b1)
		i_pwrsc_host_model.req_hold(1'b0, 1'b0);
		i_pwrsc_host_model.rd_clear();
		sup(9'h1FD, 8);
		`CHK(power_state, PWRSC_LIMP)
		`CHK(transmission_error_flag, 1'b1)
		i_pwrsc_host_model.req_hold(1'b0, 1'b1);
		#1 `CHK(spi_read_allow, 1'b1)
		i_pwrsc_host_model.req_hold(1'b0, 1'b0);
		i_pwrsc_host_model.wr(1'b0, 1'b1, 1'b0);
		`CHK(soft_reset_pulse, 1'b0)
		sup(9'h1ED, 8);
		`CHK(switching_en, 1'b0)
		sup(9'h1F5, 0);
		wait_ready();
		repeat (8) @(negedge clk);
		sup(9'h1B5, 8);
		`CHK(switching_en, 1'b0)
		`CHK(reg_reset, 1'b0)
		sup(9'h1E5, 8);
		`CHK(reg_reset, 1'b1)
		`CHK(spi_enable, 1'b0)
		sup(9'h165, 8);
		`CHK(power_state, PWRSC_SLEEP)
		`CHK(gate_regulator_en, 1'b0)
		report_and_stop();
	end
endmodule // tb_pwrsc_ctrl
